// [pkg/aap_pkg.sv]
// shared types and constants for the advanced audio port
package aap_pkg;

    // stored audio path selection, one of four
    typedef enum logic [1:0] {
        AAP_AUDIO_OFF,
        AAP_CODEC_LIN,
        AAP_CODEC_ALAW,
        AAP_PCM_SLAVE
    } aap_profile_e;

    // word read from the nonvolatile parameter store
    typedef struct packed {
        aap_profile_e profile;
        logic slaveWide;
    } aap_cfg_s;

    localparam int AAP_SYS_KHZ = 200000;
    localparam int AAP_FRAME_KHZ = 8;
    localparam int AAP_LIN_BCLK_KHZ = 480;
    localparam int AAP_ALAW_BCLK_KHZ = 120;
    localparam int AAP_SLAVE_BCLK_MIN_KHZ = 128;
    localparam int AAP_SLAVE_BCLK_MAX_KHZ = 1024;

    // nearest whole divider; exact rates are out of reach of the divider
    function automatic int aap_div_nearest(input int khz);
        return (AAP_SYS_KHZ + khz / 2) / khz;
    endfunction

    localparam int AAP_LIN_DIV_CYC = aap_div_nearest(AAP_LIN_BCLK_KHZ);
    localparam int AAP_ALAW_DIV_CYC = aap_div_nearest(AAP_ALAW_BCLK_KHZ);
    localparam logic [11:0] AAP_LIN_DIV = 12'(AAP_LIN_DIV_CYC);
    localparam logic [11:0] AAP_ALAW_DIV = 12'(AAP_ALAW_DIV_CYC);

    localparam logic [5:0] AAP_LIN_FRAME_BITS = 6'(AAP_LIN_BCLK_KHZ / AAP_FRAME_KHZ);
    localparam logic [5:0] AAP_ALAW_FRAME_BITS = 6'(AAP_ALAW_BCLK_KHZ / AAP_FRAME_KHZ);
    localparam logic [5:0] AAP_LIN_SYNC_BITS = 6'h0D;
    localparam logic [5:0] AAP_ALAW_SYNC_BITS = 6'h0E;
    localparam logic [5:0] AAP_LIN_WIDTH = 6'h0D;
    localparam logic [5:0] AAP_ALAW_WIDTH = 6'h08;
    localparam logic [5:0] AAP_SLAVE_NARROW = 6'h08;
    localparam logic [5:0] AAP_SLAVE_WIDE = 6'h10;
    localparam logic [5:0] AAP_WORD_BITS = 6'h10;
    localparam logic [5:0] AAP_BIT_IDLE = 6'h3F;

endpackage

// [rtl/aap_clk_div.sv]
// bit clock divider: one rise and one fall enable per period
`timescale 1ns/1ps
module aap_clk_div
    import aap_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [11:0] period,
    output logic riseEn,
    output logic fallEn
);
    logic [11:0] cnt_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 12'h000;
        end else if (!run || cnt_reg == period - 12'h001) begin
            cnt_reg <= 12'h000;
        end else begin
            cnt_reg <= cnt_reg + 12'h001;
        end
    end

    // odd periods give a low phase one cycle longer than the high phase
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            riseEn <= 1'b0;
            fallEn <= 1'b0;
        end else begin
            riseEn <= run && cnt_reg == 12'h000;
            fallEn <= run && cnt_reg == (period >> 1);
        end
    end
endmodule

// [rtl/aap_port.sv]
// full-duplex pcm audio port with codec-master and pcm-slave profiles
`timescale 1ns/1ps
module aap_port
    import aap_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire aap_cfg_s storedCfg,
    input wire logic [15:0] txSample,
    output logic txTaken,
    output logic [15:0] rxSample,
    output logic rxValid,
    input wire logic bclkIn,
    output logic bclkOut,
    output logic bclkOe,
    input wire logic fsyncIn,
    output logic fsyncOut,
    output logic fsyncOe,
    output logic txdOut,
    output logic txdOe,
    input wire logic rxdIn,
    output aap_profile_e activeProfile
);
    localparam int LinHalfCyc = AAP_LIN_DIV_CYC / 2;

    aap_cfg_s cfg_reg;
    logic cfgLoaded_reg;
    logic bclkS1_reg, bclkS2_reg, bclkS3_reg;
    logic fsyncS1_reg, fsyncS2_reg, fsyncPrev_reg;
    logic rxdS1_reg, rxdS2_reg;
    logic [5:0] bitCnt_reg;
    logic [5:0] bitCnt_next;
    logic [15:0] txShift_reg;
    logic [15:0] rxShift_reg;
    logic [15:0] rxShift_next;
    logic divRise, divFall;
    logic isMaster, isSlave;
    logic launch, sample, slaveStart;
    logic [5:0] width, syncLen, frameBits;

    function automatic logic [5:0] sample_width(input aap_cfg_s c);
        case (c.profile)
            AAP_CODEC_LIN: return AAP_LIN_WIDTH;
            AAP_CODEC_ALAW: return AAP_ALAW_WIDTH;
            AAP_PCM_SLAVE: return c.slaveWide ? AAP_SLAVE_WIDE : AAP_SLAVE_NARROW;
            default: return 6'h00;
        endcase
    endfunction

    // stored parameter is static; caught once after reset release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= '{profile: AAP_AUDIO_OFF, slaveWide: 1'b0};
            cfgLoaded_reg <= 1'b0;
        end else if (!cfgLoaded_reg) begin
            cfg_reg <= storedCfg;
            cfgLoaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            activeProfile <= AAP_AUDIO_OFF;
        end else begin
            activeProfile <= cfg_reg.profile;
        end
    end

    assign isMaster = cfgLoaded_reg &&
        (cfg_reg.profile == AAP_CODEC_LIN || cfg_reg.profile == AAP_CODEC_ALAW);
    assign isSlave = cfgLoaded_reg && cfg_reg.profile == AAP_PCM_SLAVE;
    assign width = sample_width(cfg_reg);
    assign syncLen = (cfg_reg.profile == AAP_CODEC_LIN) ? AAP_LIN_SYNC_BITS : AAP_ALAW_SYNC_BITS;
    assign frameBits = (cfg_reg.profile == AAP_CODEC_LIN) ? AAP_LIN_FRAME_BITS
                                                          : AAP_ALAW_FRAME_BITS;

    // nearest-rate divider for the codec profiles
    aap_clk_div uDiv (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(isMaster),
        .period((cfg_reg.profile == AAP_CODEC_LIN) ? AAP_LIN_DIV : AAP_ALAW_DIV),
        .riseEn(divRise),
        .fallEn(divFall)
    );

    // host-side pins cross into sys_clk through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclkS1_reg <= 1'b0;
            bclkS2_reg <= 1'b0;
            bclkS3_reg <= 1'b0;
            fsyncS1_reg <= 1'b0;
            fsyncS2_reg <= 1'b0;
            rxdS1_reg <= 1'b0;
            rxdS2_reg <= 1'b0;
        end else begin
            bclkS1_reg <= bclkIn;
            bclkS2_reg <= bclkS1_reg;
            bclkS3_reg <= bclkS2_reg;
            fsyncS1_reg <= fsyncIn;
            fsyncS2_reg <= fsyncS1_reg;
            rxdS1_reg <= rxdIn;
            rxdS2_reg <= rxdS1_reg;
        end
    end

    // slave follows the host clocks only
    assign launch = isMaster ? divRise : (isSlave && bclkS2_reg && !bclkS3_reg);
    assign sample = isMaster ? divFall : (isSlave && !bclkS2_reg && bclkS3_reg);
    assign slaveStart = isSlave && launch && fsyncS2_reg && !fsyncPrev_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fsyncPrev_reg <= 1'b0;
        end else if (launch) begin
            fsyncPrev_reg <= fsyncS2_reg;
        end
    end

    // slave counter holds at idle until the first sync, so no stray word
    always_comb begin
        bitCnt_next = bitCnt_reg;
        if (isMaster) begin
            bitCnt_next = (bitCnt_reg == frameBits - 6'h01) ? 6'h00 : bitCnt_reg + 6'h01;
        end else if (slaveStart) begin
            bitCnt_next = 6'h00;
        end else if (bitCnt_reg != AAP_BIT_IDLE) begin
            bitCnt_next = bitCnt_reg + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_reg <= AAP_BIT_IDLE;
        end else if (!cfgLoaded_reg) begin
            bitCnt_reg <= AAP_BIT_IDLE;
        end else if (launch) begin
            bitCnt_reg <= bitCnt_next;
        end
    end

    // clock and sync drive only in codec profiles, txd also in slave; disabled path drives nothing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclkOe <= 1'b0;
            fsyncOe <= 1'b0;
            txdOe <= 1'b0;
        end else begin
            bclkOe <= isMaster;
            fsyncOe <= isMaster;
            txdOe <= isMaster || isSlave;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclkOut <= 1'b0;
        end else if (!isMaster) begin
            bclkOut <= 1'b0;
        end else if (divRise) begin
            bclkOut <= 1'b1;
        end else if (divFall) begin
            bclkOut <= 1'b0;
        end
    end

    // long sync: high from bit 0 for the profile's sync length
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fsyncOut <= 1'b0;
        end else if (!isMaster) begin
            fsyncOut <= 1'b0;
        end else if (launch) begin
            fsyncOut <= bitCnt_next < syncLen;
        end
    end

    // transmit: word taken at bit 0, sent msb first, left justified
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txShift_reg <= 16'h0000;
            txdOut <= 1'b0;
            txTaken <= 1'b0;
        end else begin
            txTaken <= 1'b0;
            if (!(isMaster || isSlave)) begin
                txdOut <= 1'b0;
            end else if (launch && bitCnt_next == 6'h00) begin
                txdOut <= txSample[15];
                txShift_reg <= {txSample[14:0], 1'b0};
                txTaken <= 1'b1;
            end else if (launch && bitCnt_next < width) begin
                txdOut <= txShift_reg[15];
                txShift_reg <= {txShift_reg[14:0], 1'b0};
            end else if (launch) begin
                txdOut <= 1'b0;
            end
        end
    end

    assign rxShift_next = {rxShift_reg[14:0], rxdS2_reg};

    // receive on the falling edge; word left justified, low bits zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxShift_reg <= 16'h0000;
            rxSample <= 16'h0000;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (sample && bitCnt_reg < width) begin
                rxShift_reg <= rxShift_next;
                if (bitCnt_reg == width - 6'h01) begin
                    rxSample <= rxShift_next << (AAP_WORD_BITS - width);
                    rxValid <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_off_silent: assert property (
        cfgLoaded_reg && cfg_reg.profile == AAP_AUDIO_OFF |=> !bclkOe && !fsyncOe && !txdOe)
        else $error("disabled path drives a pin");
    a_slave_no_clk: assert property (
        isSlave |=> !bclkOe && !fsyncOe && $stable(bclkOut))
        else $error("slave drives bit clock or sync");
    a_master_drives: assert property (
        isMaster ##1 isMaster |-> bclkOe && fsyncOe && txdOe)
        else $error("codec profile not driving clocks");
    a_frame_wrap: assert property (
        isMaster && launch && bitCnt_reg == frameBits - 6'h01 |=> bitCnt_reg == 6'h00)
        else $error("codec frame length wrong");
    a_sync_len: assert property (
        isMaster && launch |=> fsyncOut == (bitCnt_reg < syncLen))
        else $error("frame sync length wrong");
    a_lin_half: assert property (
        cfg_reg.profile == AAP_CODEC_LIN && $rose(bclkOut) |-> ##LinHalfCyc $fell(bclkOut))
        else $error("bit clock high phase wrong");
    a_rx_width: assert property (
        rxValid |-> $past(bitCnt_reg) == width - 6'h01 &&
            (rxSample & (16'hFFFF >> width)) == 16'h0000)
        else $error("received word width wrong");
    a_single_word: assert property (
        txTaken |=> !txTaken [*8])
        else $error("more than one word per frame");
    a_slave_start: assert property (
        slaveStart |=> bitCnt_reg == 6'h00 && txTaken && txdOut == $past(txSample[15]))
        else $error("slave frame start missed");
    a_slave_follow: assert property (
        isSlave && !launch |=> $stable(bitCnt_reg))
        else $error("slave counter moved without host clock");

    c_lin_rx: cover property (rxValid && cfg_reg.profile == AAP_CODEC_LIN);
    c_alaw_rx: cover property (rxValid && cfg_reg.profile == AAP_CODEC_ALAW);
    c_slave_wide: cover property (rxValid && isSlave && cfg_reg.slaveWide);
    c_slave_tx: cover property (txTaken && isSlave);
endmodule

// [testbench/aap_far_end.sv]
// behavioural far-end audio device: codec in master profiles, host in slave
`timescale 1ns/1ps
module aap_far_end (
    input wire logic bclk,
    input wire logic fsync,
    input wire logic txd,
    input wire logic [15:0] rxWord,
    output logic bclkHost,
    output logic fsyncHost,
    output logic rxd,
    output logic [15:0] txWord
);
    int bitNum = 99;
    logic syncPrev = 1'b0;
    initial begin
        bclkHost = 1'b0;
        fsyncHost = 1'b0;
        rxd = 1'b0;
        txWord = 16'h0000;
    end
    // launch on rise so the port's fall sample sees settled data
    always @(posedge bclk) begin
        // later than the bench's strobe, so a reset's dropped sync is seen
        #2;
        bitNum = (fsync && !syncPrev) ? 0 : bitNum + 1;
        syncPrev = fsync;
        rxd = (bitNum < 16) ? rxWord[15 - bitNum] : ~rxd;
    end
    always @(negedge bclk) begin
        if (bitNum < 16) txWord[15 - bitNum] = txd;
    end
    // host clocks run only inside a frame, then stand still
    task automatic host_frame(input int bits, input int syncBits, input int halfNs);
        fsyncHost = 1'b1;
        for (int i = 0; i < bits; i++) begin
            #(halfNs);
            bclkHost = 1'b1;
            #(halfNs);
            bclkHost = 1'b0;
            fsyncHost = (i + 1 < syncBits);
        end
    endtask
endmodule

// [testbench/testbench.sv]
// self-checking testbench for the audio port
`timescale 1ns/1ps
module testbench;
    import aap_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    aap_cfg_s storedCfg = '0;
    logic [15:0] txSample = 16'hA5C3;
    logic [15:0] rxWord = 16'h3C96;
    logic txTaken, rxValid, bclkOut, bclkOe, fsyncOut, fsyncOe, txdOut, txdOe, rxd;
    logic bclkHost, fsyncHost;
    logic [15:0] rxSample, txWord;
    aap_profile_e activeProfile;
    wire logic bclk = bclkOe ? bclkOut : bclkHost;
    wire logic fsync = fsyncOe ? fsyncOut : fsyncHost;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    aap_port aap_port_i (.sys_clk(sys_clk), .rst_b(rst_b), .storedCfg(storedCfg),
        .txSample(txSample), .txTaken(txTaken), .rxSample(rxSample), .rxValid(rxValid),
        .bclkIn(bclk), .bclkOut(bclkOut), .bclkOe(bclkOe), .fsyncIn(fsync),
        .fsyncOut(fsyncOut), .fsyncOe(fsyncOe), .txdOut(txdOut), .txdOe(txdOe),
        .rxdIn(rxd), .activeProfile(activeProfile));
    aap_far_end aap_far_end_i (.bclk(bclk), .fsync(fsync), .txd(txdOut), .rxWord(rxWord),
        .bclkHost(bclkHost), .fsyncHost(fsyncHost), .rxd(rxd), .txWord(txWord));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic start(input aap_profile_e prof, input logic wide);
        rst_b = 1'b0;
        storedCfg = {prof, wide};
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("activeProfile", 32'(activeProfile), 32'(prof));
    endtask
    task automatic wait_taken(input int lim);
        for (int n = 0; n < lim && txTaken !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        check("txTaken", 32'(txTaken), 32'h1);
    endtask
    task automatic codec_run(input aap_profile_e prof, input int khz, input int w,
        input int syncBits, input bit frame);
        int p = (2 * AAP_SYS_KHZ / khz + 1) / 2;
        int cnt = 0;
        int per = 0;
        int hits = 0;
        int t0;
        logic prevB = 1'b1;
        logic [15:0] mask = 16'hFFFF << (16 - w);
        start(prof, 1'b0);
        check("oe", 32'({bclkOe, fsyncOe, txdOe}), 32'h7);
        wait_taken(4 * p);
        t0 = cyc;
        check("frame start", 32'({bclkOut, fsyncOut}), 32'h3);
        while (fsyncOut === 1'b1 && cnt < 30 * p) begin
            if (bclkOut === 1'b1 && prevB === 1'b0 && per == 0) per = cnt;
            if (rxValid === 1'b1) hits++;
            prevB = bclkOut;
            cnt++;
            @(posedge sys_clk);
            #1;
        end
        check("bit period", per, p);
        check("sync length", cnt, syncBits * p);
        check("rx words", hits, 32'h1);
        check("rxSample", 32'(rxSample), 32'(rxWord & mask));
        check("tx word", 32'(txWord & mask), 32'(txSample & mask));
        if (frame) begin
            wait_taken(khz / AAP_FRAME_KHZ * p + 10);
            check("frame period", cyc - t0, khz / AAP_FRAME_KHZ * p);
        end
    endtask
    task automatic slave_run(input logic wide, input int halfNs);
        int w = wide ? 16 : 8;
        logic [15:0] mask = 16'hFFFF << (16 - w);
        start(AAP_PCM_SLAVE, wide);
        check("oe", 32'({bclkOe, fsyncOe, txdOe}), 32'h1);
        aap_far_end_i.host_frame(w + 2, w, halfNs);
        repeat (8) @(posedge sys_clk);
        #1;
        check("slave tx", 32'(txWord & mask), 32'(txSample & mask));
        check("slave rx", 32'(rxSample), 32'(rxWord & mask));
    endtask
    task automatic off_run();
        logic any = 1'b0;
        start(AAP_AUDIO_OFF, 1'b0);
        repeat (2000) begin
            @(posedge sys_clk);
            #1;
            any = any | bclkOe | fsyncOe | txdOe | txTaken | rxValid;
        end
        check("disabled activity", 32'(any), 32'h0);
    endtask
    initial begin
        codec_run(AAP_CODEC_LIN, AAP_LIN_BCLK_KHZ, 13, 13, 1'b1);
        codec_run(AAP_CODEC_ALAW, AAP_ALAW_BCLK_KHZ, 8, 14, 1'b1);
        slave_run(1'b1, 489);
        slave_run(1'b0, 3900);
        off_run();
        final_report();
    end
    // about a quarter above the expected run of some 71000 cycles
    initial begin
        #450000;
        err_count++;
        final_report();
    end
endmodule
